// File: sim/eis_pin_src.sv
// Signal sources standing on the grouped port pins.
// Assumes the bench requests levels synchronous to clk_sys.
`timescale 1ns/1ps
module eis_pin_src (
    // Clock.
    input wire clk_sys,
    // Requested levels, port B then port F then port A.
    input wire [11:0] lvl_req,
    // Pin levels, idle high as with pull-ups.
    output reg [3:0] porta_pins = 4'hF,
    output reg [2:0] portf_pins = 3'h7,
    output reg [4:0] portb_pins = 5'h1F
);
    // Pins follow a request one edge later, like an external driver.
    always @(posedge clk_sys)
    begin
        {portb_pins, portf_pins, porta_pins} <= lvl_req;
    end
endmodule // eis_pin_src

// File: sim/eis_sense_ctrl_sva.sv
// Checker of register and request behaviour of the sensitivity block.
// Assumes the top runs with clk_en held high.
`timescale 1ns/1ps
`include "eis_defines.vh"
module eis_sense_ctrl_sva (
    // Clock and reset.
    input wire clk_sys,
    input wire rst_n,
    // Register port and CPU level.
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    input wire cpu_level_hi_bit,
    input wire cpu_level_lo_bit,
    // Pins, requests and registers.
    input wire [3:0] porta_pins,
    input wire [3:0] porta_irq_en,
    input wire [4:0] portb_pins,
    input wire [4:0] portb_irq_en,
    input wire ext_irq_a_q,
    input wire ext_irq_f_q,
    input wire ext_irq_b_low_q,
    input wire ext_irq_b_high_q,
    input wire [7:0] irq_priority_0_q,
    input wire [7:0] irq_priority_3_q,
    input wire [7:0] ext_irq_sense_ctrl_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Write steps: a control write, gated by the level, or none at all.
    sequence s_ctrl_wr;
        reg_wr && reg_addr == `EIS_ADDR_CTRL;
    endsequence
    sequence s_lvl3_wr;
        s_ctrl_wr ##0 (cpu_level_hi_bit && cpu_level_lo_bit);
    endsequence
    sequence s_quiet;
        !reg_wr;
    endsequence
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
        else $error("read data not idle");
    AST_CTRL_WR: assert property (s_lvl3_wr |=> ext_irq_sense_ctrl_q ==
        ($past(reg_wdata) & `EIS_CTRL_WMASK)) else $error("ctrl write");
    AST_CTRL_GATE: assert property (s_ctrl_wr ##0
        !(cpu_level_hi_bit && cpu_level_lo_bit)
        |=> $stable(ext_irq_sense_ctrl_q)) else $error("gated write");
    AST_CLR: assert property (s_lvl3_wr ##0 ((reg_wdata ^
        ext_irq_sense_ctrl_q) & `EIS_CTRL_WMASK) != 8'h00 |=> !(ext_irq_a_q
        || ext_irq_f_q || ext_irq_b_low_q || ext_irq_b_high_q))
        else $error("pending not cleared");
    AST_PRIO3: assert property (irq_priority_3_q[7:4] == 4'hF)
        else $error("fixed nibble");
    AST_PRIO_L0: assert property (reg_wr && reg_addr == `EIS_ADDR_PRIO0 &&
        reg_wdata[1:0] == `EIS_PRIO_LEVEL0 |=> irq_priority_0_q[1:0] ==
        $past(irq_priority_0_q[1:0])) else $error("level 0 stored");
    AST_A_FALL: assert property (s_quiet ##0 ($fell(porta_pins[2]) &&
        porta_irq_en[2] && ext_irq_sense_ctrl_q[4:2] == 3'h0)
        |=> ext_irq_a_q) else $error("port A fall missed");
    AST_B_INV: assert property (s_quiet ##0 ($rose(portb_pins[3]) &&
        portb_irq_en[3] && ext_irq_sense_ctrl_q[7:5] == 3'h5)
        |=> ext_irq_b_low_q) else $error("port B inverted edge missed");
    AST_B_LVL: assert property (s_quiet ##0 (!portb_pins[4] &&
        portb_irq_en[4] && ext_irq_sense_ctrl_q[7:6] == 2'h0)
        |=> ext_irq_b_high_q) else $error("port B low level missed");
endmodule // eis_sense_ctrl_sva

bind eis_sense_ctrl eis_sense_ctrl_sva i_sva (.clk_sys, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .cpu_level_hi_bit,
    .cpu_level_lo_bit, .porta_pins, .porta_irq_en, .portb_pins,
    .portb_irq_en, .ext_irq_a_q, .ext_irq_f_q,
    .ext_irq_b_low_q, .ext_irq_b_high_q, .irq_priority_0_q,
    .irq_priority_3_q, .ext_irq_sense_ctrl_q);

// File: sim/eis_sense_ctrl_tb.sv
// Self-checking bench of the sensitivity block: registers and pin events.
// Assumes the defines header is on the include path.
`timescale 1ns/1ps
`include "eis_defines.vh"
module eis_sense_ctrl_tb;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg lvl_lo = 1'b1;
    reg lvl_hi = 1'b1;
    reg [11:0] en = 12'hFFF;
    reg [11:0] lvl_req = 12'hFFF;
    reg [3:0] irq_ack = 4'h0;
    wire [7:0] rdata;
    wire [3:0] pa;
    wire [2:0] pf;
    wire [4:0] pb;
    wire [3:0] pend;
    wire [7:0] p1;
    wire [7:0] p2;
    wire [7:0] ctl;
    integer errors = 0;
    integer cmp_count = 0;
    integer m;
    // Clock of 4 ns.
    always #2 clk_sys = ~clk_sys;
    eis_pin_src i_src (.clk_sys, .lvl_req, .porta_pins(pa),
        .portf_pins(pf), .portb_pins(pb));
    eis_sense_ctrl i_dut (.clk_sys, .rst_n, .clk_en(1'b1), .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q(rdata),
        .cpu_level_hi_bit(lvl_hi), .cpu_level_lo_bit(lvl_lo),
        .porta_pins(pa), .porta_irq_en(en[3:0]), .portf_pins(pf),
        .portf_irq_en(en[6:4]), .portb_pins(pb), .portb_irq_en(en[11:7]),
        .irq_ack, .ext_irq_a_q(pend[0]), .ext_irq_f_q(pend[1]),
        .ext_irq_b_low_q(pend[2]), .ext_irq_b_high_q(pend[3]),
        .irq_priority_0_q(), .irq_priority_1_q(p1), .irq_priority_2_q(p2),
        .irq_priority_3_q(), .ext_irq_sense_ctrl_q(ctl));
    task report_and_stop;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task check(input [63:0] name, input [7:0] seen, input [7:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
    begin
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check("rdata", rdata, exp);
    end
    endtask
    // Expected request of one source for a mode and a pin step.
    function f(input [1:0] s, input iv, input [1:0] ev);
        reg [1:0] e;
    begin
        e = (iv && s != 2'h0 && s != 2'h3) ? ~s : s;
        case (ev)
            2'h0: f = e == 2'h0 && iv;
            2'h1: f = e == 2'h0 || e[1];
            2'h2: f = e == 2'h0;
            default: f = e == 2'h0 || e[0];
        endcase
    end
    endfunction
    // Sets pins and pulses acknowledges, then compares the pendings.
    task step(input [11:0] lv, input [3:0] ack, input [2:0] md,
        input [1:0] ev);
        reg [3:0] exp;
    begin
        @(posedge clk_sys);
        // Taken after the edge so that a new enable value is seen.
        exp = {f(md[2:1], 1'b0, ev), f(md[2:1], md[0], ev),
            f(md[2:1], 1'b0, ev), f(md[2:1], md[0], ev)} & {4{|en}};
        lvl_req <= lv;
        irq_ack <= ack;
        @(posedge clk_sys);
        irq_ack <= 4'h0;
        repeat (3) @(posedge clk_sys);
        #1 check("pending", {4'h0, pend}, {4'h0, exp});
    end
    endtask
    // Main sequence of tests.
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`EIS_ADDR_PRIO0, `EIS_PRIO_RST);
        rd(`EIS_ADDR_PRIO3, `EIS_PRIO_RST);
        rd(`EIS_ADDR_CTRL, `EIS_CTRL_RST);
        rd(8'h30, 8'h00);
        check("prio1", p1, `EIS_PRIO_RST);
        wr(`EIS_ADDR_PRIO0, 8'h66);
        rd(`EIS_ADDR_PRIO0, 8'h77);
        wr(`EIS_ADDR_PRIO1, 8'h5A);
        #1 check("prio1", p1, 8'h5F);
        wr(`EIS_ADDR_PRIO2, 8'hCF);
        wr(`EIS_ADDR_PRIO2, 8'h64);
        rd(`EIS_ADDR_PRIO2, 8'h44);
        check("prio2", p2, 8'h44);
        wr(`EIS_ADDR_PRIO3, 8'h00);
        rd(`EIS_ADDR_PRIO3, `EIS_PRIO3_FIXED);
        @(posedge clk_sys);
        lvl_lo <= 1'b0;
        wr(`EIS_ADDR_CTRL, 8'h40);
        rd(`EIS_ADDR_CTRL, 8'h00);
        @(posedge clk_sys);
        lvl_lo <= 1'b1;
        lvl_hi <= 1'b0;
        wr(`EIS_ADDR_CTRL, 8'h40);
        rd(`EIS_ADDR_CTRL, 8'h00);
        @(posedge clk_sys);
        lvl_hi <= 1'b1;
        wr(`EIS_ADDR_CTRL, 8'h40);
        rd(`EIS_ADDR_CTRL, 8'h40);
        check("ctrl", ctl, 8'h40);
        $display("test registers done");
        for (m = 0; m < 8; m = m + 1)
        begin
            wr(`EIS_ADDR_CTRL, {m[2:1], m[0], m[2:1], m[0], 2'b00});
            step(12'hFFF, 4'hF, m[2:0], 2'h0);
            step(12'h3DB, 4'h0, m[2:0], 2'h1);
            step(12'h3DB, 4'hF, m[2:0], 2'h2);
            step(12'hFFF, 4'h0, m[2:0], 2'h3);
        end
        @(posedge clk_sys);
        en <= 12'h000;
        step(12'h3DB, 4'hF, 3'h7, 2'h1);
        $display("test pin events done");
        // A second reset in mid-run restores the reset values.
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`EIS_ADDR_CTRL, `EIS_CTRL_RST);
        rd(`EIS_ADDR_PRIO2, `EIS_PRIO_RST);
        $display("test second reset done");
        report_and_stop;
    end
    // Watchdog: the tests take well under 1000 cycles.
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        errors = errors + 1;
        report_and_stop;
    end
endmodule // eis_sense_ctrl_tb

// File: verilog/eis_defines.vh
// Constants of the external interrupt sensitivity block: register offsets,
// field positions, reset values and sensitivity codes.
// Assumes it is included once per compilation unit by its bare name.
`ifndef EIS_DEFINES_VH
`define EIS_DEFINES_VH

// Register byte addresses on the plain register port.
`define EIS_ADDR_PRIO0 8'h24
`define EIS_ADDR_PRIO1 8'h25
`define EIS_ADDR_PRIO2 8'h26
`define EIS_ADDR_PRIO3 8'h27
`define EIS_ADDR_CTRL 8'h28
`define EIS_ADDR_STATUS 8'h29

// Reset values.
`define EIS_PRIO_RST 8'hFF
`define EIS_CTRL_RST 8'h00

// Field positions in the sense control register.
`define EIS_PB_FIELD_HI 7
`define EIS_PB_FIELD_LO 6
`define EIS_PB_INV_BIT 5
`define EIS_PAF_FIELD_HI 4
`define EIS_PAF_FIELD_LO 3
`define EIS_PA_INV_BIT 2
`define EIS_CTRL_WMASK 8'hFC

// Fixed upper nibble of the last priority register.
`define EIS_PRIO3_FIXED 8'hF0

// Sensitivity field codes.
`define EIS_SENSE_FALL_LOW 2'h0
`define EIS_SENSE_RISE 2'h1
`define EIS_SENSE_FALL 2'h2
`define EIS_SENSE_BOTH 2'h3

// Priority pair pattern that cannot be stored (level 0).
`define EIS_PRIO_LEVEL0 2'h2

`endif

// File: verilog/eis_pin_detect.v
// One pin detector: decodes a sensitivity field and a polarity bit into an
// event for a single pin.
// Assumes the pin and its previous sample are synchronous to clk_sys.
`timescale 1ns/1ps
`include "eis_defines.vh"

module eis_pin_detect (
    // Pin levels.
    input wire pin_now,
    input wire pin_prev,
    // Configuration.
    input wire [1:0] sense,
    input wire invert,
    // Result.
    output reg hit
);

    reg rise;
    reg fall;

    // Inversion swaps the roles of the rising and falling events.
    always @*
    begin
        rise = pin_now & ~pin_prev;
        fall = ~pin_now & pin_prev;
        case (sense)
            `EIS_SENSE_FALL_LOW: hit = invert ? (rise | pin_now)
                                              : (fall | ~pin_now);
            `EIS_SENSE_RISE: hit = invert ? fall : rise;
            `EIS_SENSE_FALL: hit = invert ? rise : fall;
            `EIS_SENSE_BOTH: hit = rise | fall;
            default: hit = 1'b0;
        endcase
    end

endmodule // eis_pin_detect

// File: verilog/eis_sense_ctrl.v
// Top of the external interrupt sensitivity block: the priority registers,
// the sense control register, pin edge/level detection and the four
// pending requests.
// Assumes pins and the register port are synchronous to clk_sys; the
// interrupt core pulses ack inputs to retire a pending request.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "eis_defines.vh"

// Function
// - Sources trigger on fall, rise, both, or fall+low; rise+high for a and b_low.
// - Writing a changed sense or polarity value clears all pending requests.
// - Sense control register resets to zero: fall+low, no inversion.
// - Bits 7:6 set port B sources; bits 4:3 set port A and F.
// - Port A and port B low decode with polarity inversion applied.
// - Port F and port B high decode without polarity influence.
// - Bit 5 inverts the port B pins 3..0 sensitivity.
// - Bit 2 inverts the port A pins 3..0 sensitivity.
// - Priority registers at 24h..27h reset to all ones; control at 28h.
// - A priority pair written as level 0 keeps its old value.
// - Pins of a group are detected separately then ORed into one request.
module eis_sense_ctrl (
    // Clock, reset and enable.
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // Current CPU interrupt level bits.
    input wire cpu_level_hi_bit,
    input wire cpu_level_lo_bit,
    // Port pins and their interrupt enables.
    input wire [3:0] porta_pins,
    input wire [3:0] porta_irq_en,
    input wire [2:0] portf_pins,
    input wire [2:0] portf_irq_en,
    input wire [4:0] portb_pins,
    input wire [4:0] portb_irq_en,
    // Acknowledges from the interrupt core, one per request.
    input wire [3:0] irq_ack,
    // Pending requests.
    output reg ext_irq_a_q,
    output reg ext_irq_f_q,
    output reg ext_irq_b_low_q,
    output reg ext_irq_b_high_q,
    // Configuration views for the interrupt core.
    output reg [7:0] irq_priority_0_q,
    output reg [7:0] irq_priority_1_q,
    output reg [7:0] irq_priority_2_q,
    output reg [7:0] irq_priority_3_q,
    output reg [7:0] ext_irq_sense_ctrl_q
);

    // Merges a written priority byte, keeping any pair written as level 0.
    function [7:0] prio_merge;
        input [7:0] old_v;
        input [7:0] new_v;
        integer k;
        begin
            prio_merge = new_v;
            for (k = 0; k < 4; k = k + 1)
            begin
                if (new_v[2*k+1 -: 2] == `EIS_PRIO_LEVEL0)
                    prio_merge[2*k+1 -: 2] = old_v[2*k+1 -: 2];
            end
        end
    endfunction

    reg [3:0] porta_prev_q;
    reg [2:0] portf_prev_q;
    reg [4:0] portb_prev_q;
    reg [7:0] ctrl_d;
    reg [7:0] rdata_d;
    wire level3;
    wire ctrl_wr;
    wire cfg_change;
    wire [1:0] pb_sense;
    wire [1:0] paf_sense;
    wire pb_inv;
    wire pa_inv;
    wire [3:0] hit_a;
    wire [2:0] hit_f;
    wire [4:0] hit_b;
    wire req_a;
    wire req_f;
    wire req_bl;
    wire req_bh;

    assign level3 = cpu_level_hi_bit & cpu_level_lo_bit;
    assign ctrl_wr = reg_wr & (reg_addr == `EIS_ADDR_CTRL) & level3;

    // Reserved bits are forced to zero whatever software writes.
    always @*
    begin
        ctrl_d = ext_irq_sense_ctrl_q;
        if (ctrl_wr)
            ctrl_d = reg_wdata & `EIS_CTRL_WMASK;
    end

    assign cfg_change = ctrl_wr & (ctrl_d != ext_irq_sense_ctrl_q);

    assign pb_sense = ext_irq_sense_ctrl_q[`EIS_PB_FIELD_HI:`EIS_PB_FIELD_LO];
    assign paf_sense =
        ext_irq_sense_ctrl_q[`EIS_PAF_FIELD_HI:`EIS_PAF_FIELD_LO];
    assign pb_inv = ext_irq_sense_ctrl_q[`EIS_PB_INV_BIT];
    assign pa_inv = ext_irq_sense_ctrl_q[`EIS_PA_INV_BIT];

    eis_pin_detect u_det_a0 (
        .pin_now(porta_pins[0]),
        .pin_prev(porta_prev_q[0]),
        .sense(paf_sense),
        .invert(pa_inv),
        .hit(hit_a[0])
    );
    eis_pin_detect u_det_a1 (
        .pin_now(porta_pins[1]),
        .pin_prev(porta_prev_q[1]),
        .sense(paf_sense),
        .invert(pa_inv),
        .hit(hit_a[1])
    );
    eis_pin_detect u_det_a2 (
        .pin_now(porta_pins[2]),
        .pin_prev(porta_prev_q[2]),
        .sense(paf_sense),
        .invert(pa_inv),
        .hit(hit_a[2])
    );
    eis_pin_detect u_det_a3 (
        .pin_now(porta_pins[3]),
        .pin_prev(porta_prev_q[3]),
        .sense(paf_sense),
        .invert(pa_inv),
        .hit(hit_a[3])
    );

    eis_pin_detect u_det_f0 (
        .pin_now(portf_pins[0]),
        .pin_prev(portf_prev_q[0]),
        .sense(paf_sense),
        .invert(1'b0),
        .hit(hit_f[0])
    );
    eis_pin_detect u_det_f1 (
        .pin_now(portf_pins[1]),
        .pin_prev(portf_prev_q[1]),
        .sense(paf_sense),
        .invert(1'b0),
        .hit(hit_f[1])
    );
    eis_pin_detect u_det_f2 (
        .pin_now(portf_pins[2]),
        .pin_prev(portf_prev_q[2]),
        .sense(paf_sense),
        .invert(1'b0),
        .hit(hit_f[2])
    );

    // port B low pins with inversion.
    eis_pin_detect u_det_b0 (
        .pin_now(portb_pins[0]),
        .pin_prev(portb_prev_q[0]),
        .sense(pb_sense),
        .invert(pb_inv),
        .hit(hit_b[0])
    );
    eis_pin_detect u_det_b1 (
        .pin_now(portb_pins[1]),
        .pin_prev(portb_prev_q[1]),
        .sense(pb_sense),
        .invert(pb_inv),
        .hit(hit_b[1])
    );
    eis_pin_detect u_det_b2 (
        .pin_now(portb_pins[2]),
        .pin_prev(portb_prev_q[2]),
        .sense(pb_sense),
        .invert(pb_inv),
        .hit(hit_b[2])
    );
    eis_pin_detect u_det_b3 (
        .pin_now(portb_pins[3]),
        .pin_prev(portb_prev_q[3]),
        .sense(pb_sense),
        .invert(pb_inv),
        .hit(hit_b[3])
    );
    // port B high pin without inversion.
    eis_pin_detect u_det_b4 (
        .pin_now(portb_pins[4]),
        .pin_prev(portb_prev_q[4]),
        .sense(pb_sense),
        .invert(1'b0),
        .hit(hit_b[4])
    );

    assign req_a = |(hit_a & porta_irq_en);
    assign req_f = |(hit_f & portf_irq_en);
    assign req_bl = |(hit_b[3:0] & portb_irq_en[3:0]);
    assign req_bh = hit_b[4] & portb_irq_en[4];

    // Read mux; the status view at 29h shows the four pending requests.
    always @*
    begin
        case (reg_addr)
            `EIS_ADDR_PRIO0: rdata_d = irq_priority_0_q;
            `EIS_ADDR_PRIO1: rdata_d = irq_priority_1_q;
            `EIS_ADDR_PRIO2: rdata_d = irq_priority_2_q;
            `EIS_ADDR_PRIO3: rdata_d = irq_priority_3_q;
            `EIS_ADDR_CTRL: rdata_d = ext_irq_sense_ctrl_q;
            `EIS_ADDR_STATUS: rdata_d = {4'h0, ext_irq_b_high_q,
                ext_irq_b_low_q, ext_irq_f_q, ext_irq_a_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // Register file, pin history and read data.
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_priority_0_q <= `EIS_PRIO_RST;
            irq_priority_1_q <= `EIS_PRIO_RST;
            irq_priority_2_q <= `EIS_PRIO_RST;
            irq_priority_3_q <= `EIS_PRIO_RST;
            ext_irq_sense_ctrl_q <= `EIS_CTRL_RST;
            porta_prev_q <= 4'hF;
            portf_prev_q <= 3'h7;
            portb_prev_q <= 5'h1F;
            reg_rdata_q <= 8'h00;
        end
        else if (clk_en)
        begin
            porta_prev_q <= porta_pins;
            portf_prev_q <= portf_pins;
            portb_prev_q <= portb_pins;
            ext_irq_sense_ctrl_q <= ctrl_d;
            reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
            if (reg_wr)
            begin
                case (reg_addr)
                    `EIS_ADDR_PRIO0: irq_priority_0_q <=
                        prio_merge(irq_priority_0_q, reg_wdata);
                    `EIS_ADDR_PRIO1: irq_priority_1_q <=
                        prio_merge(irq_priority_1_q, reg_wdata);
                    `EIS_ADDR_PRIO2: irq_priority_2_q <=
                        prio_merge(irq_priority_2_q, reg_wdata);
                    `EIS_ADDR_PRIO3: irq_priority_3_q <= `EIS_PRIO3_FIXED |
                        prio_merge(irq_priority_3_q, reg_wdata);
                    default: ;
                endcase
            end
        end
    end

    // Pending requests: a new hit wins over an ack; a config change clears.
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ext_irq_a_q <= 1'b0;
            ext_irq_f_q <= 1'b0;
            ext_irq_b_low_q <= 1'b0;
            ext_irq_b_high_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cfg_change)
            begin
                ext_irq_a_q <= 1'b0;
                ext_irq_f_q <= 1'b0;
                ext_irq_b_low_q <= 1'b0;
                ext_irq_b_high_q <= 1'b0;
            end
            else
            begin
                ext_irq_a_q <= req_a | (ext_irq_a_q & ~irq_ack[0]);
                ext_irq_f_q <= req_f | (ext_irq_f_q & ~irq_ack[1]);
                ext_irq_b_low_q <= req_bl | (ext_irq_b_low_q & ~irq_ack[2]);
                ext_irq_b_high_q <= req_bh |
                    (ext_irq_b_high_q & ~irq_ack[3]);
            end
        end
    end

endmodule // eis_sense_ctrl
